// ==== bsg_defs.svh ====
// Purpose: Register offsets, field positions, reset values and timing figures of the buzzer.
// Assumes: Included by its bare name.
// Notes:   Byte offsets on a 32-bit classic Wishbone bus.
`ifndef BSG_DEFS_SVH
`define BSG_DEFS_SVH

// ****************************************************************************
// Register offsets
// ****************************************************************************
`define BSG_OFS_CTRL    8'h00
`define BSG_OFS_SETUP   8'h04
`define BSG_OFS_STATUS  8'h08

// ****************************************************************************
// Control word fields
// ****************************************************************************
`define BSG_B_CONT      0
`define BSG_B_ENV_EN    1
`define BSG_B_ENV_RST   2
`define BSG_B_ENV_TIME  3
`define BSG_B_SHOT_LEN  4
`define BSG_B_SHOT_TRIG 5
`define BSG_B_SHOT_STOP 6

// ****************************************************************************
// Setup and status word fields
// ****************************************************************************
`define BSG_F_FREQ_LSB  0
`define BSG_F_LEVEL_LSB 4
`define BSG_F_ENVL_LSB  0
`define BSG_B_TONE      4

// ****************************************************************************
// Reset values
// ****************************************************************************
`define BSG_RST_FREQ    3'h0
`define BSG_RST_LEVEL   3'h0

// ****************************************************************************
// Timing figures
// ****************************************************************************
`define BSG_CLK_HZ       250000000
`define BSG_OSC_HZ       32768
`define BSG_TB_HZ        256
`define BSG_ENV_LONG_US  125000
`define BSG_ENV_SHORT_US 62500
`define BSG_SHOT_LONG_US 125000
`define BSG_SHOT_SHORT_US 31250
`define BSG_US_PER_S     1000000

`endif

// ==== bsg_pkg.sv ====
// Purpose: Types shared by the buzzer sound generator.
// Assumes: Nothing beyond the defines header.
// Notes:   No constants live here; they are in bsg_defs.svh.
package bsg_pkg;

  typedef enum logic [1:0] {
    BSG_SHOT_IDLE  = 2'h0,
    BSG_SHOT_ARMED = 2'h1,
    BSG_SHOT_PLAY  = 2'h3
  } bsg_shot_e;

  typedef struct packed {
    logic       continuous_enable;
    logic       envelope_enable;
    logic       envelope_step_time_select;
    logic       one_shot_length_select;
    logic [2:0] frequency_select;
    logic [2:0] level_select;
  } bsg_ctrl_s;

  typedef struct packed {
    logic [5:0] period;
    logic [5:0] high;
  } bsg_shape_s;

endpackage : bsg_pkg

// ==== bsg_top.sv ====
// Purpose: Buzzer tone generator with envelope and one-shot burst, Wishbone registers.
// Assumes: Single 250 MHz clock; low-speed oscillator ticks are derived from it.
// Notes:   The tone runs on half-periods of the low-speed oscillator.
//
// Behaviour
// - Tone drives the pin while continuous or one-shot active; otherwise pin low.
// - Forced stop ends a one-shot at once, not waiting for 256 Hz.
// - Frequency code 0..7 divides oscillator by 8,10,12,14,16,20,24,28.
// - Divisors 8,10,16,20: code 0 gives 8 high parts, minus one per step.
// - Divisors 12,14,24,28: code 0 gives 12 high parts, down to 5.
// - Level code sets high fraction; all zeros loudest, all ones quietest.
// - With envelope enabled, level comes from the envelope step counter.
// - Continuous start with envelope begins at level 1, stepping toward 8.
// - Without envelope the fixed level select field is used.
// - Envelope restart returns the step counter to level 1.
// - Envelope holds at level 8 until output off or restart.
// - Step-time select picks 125 ms or 62.5 ms between envelope steps.
// - Length select picks a one-shot burst of 125 ms or 31.25 ms.
// - One-shot trigger starts the tone at the next 256 Hz edge.
// - The burst ends automatically after its length, on a 256 Hz edge.
// - Trigger bit reads one from an accepted trigger until the burst ends, zero otherwise.
// - An accepted trigger write clears the envelope enable.
// - A burst uses the current frequency and level selections only.
// - Trigger and forced-stop writes are ignored while continuous output is on.
// - Reset clears continuous enable, so the pin is low.
`timescale 1ns/1ps
`include "bsg_defs.svh"

module bsg_top #(
  parameter int HALF_DIV = `BSG_CLK_HZ / (2 * `BSG_OSC_HZ),
  parameter int AW       = 8
) (
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  input  wire logic          wb_cyc_i,
  input  wire logic          wb_stb_i,
  input  wire logic          wb_we_i,
  input  wire logic [AW-1:0] wb_adr_i,
  input  wire logic [3:0]    wb_sel_i,
  input  wire logic [31:0]   wb_dat_i,
  output logic      [31:0]   wb_dat_o,
  output logic               wb_ack_o,
  output logic               buzzer_port_pin_o
);

  // ****************************************************************************
  // Derived counts
  // ****************************************************************************
  localparam int HALF_PER_TB  = 2 * `BSG_OSC_HZ / `BSG_TB_HZ;
  localparam int ENV_LONG_T   = `BSG_ENV_LONG_US * `BSG_TB_HZ / `BSG_US_PER_S;
  localparam int ENV_SHORT_T  = `BSG_ENV_SHORT_US * `BSG_TB_HZ / `BSG_US_PER_S;
  localparam int SHOT_LONG_T  = `BSG_SHOT_LONG_US * `BSG_TB_HZ / `BSG_US_PER_S;
  localparam int SHOT_SHORT_T = `BSG_SHOT_SHORT_US * `BSG_TB_HZ / `BSG_US_PER_S;
  localparam logic [2:0] LEVEL_MIN = 3'h7;

  // ****************************************************************************
  // Helpers
  // ****************************************************************************
  function automatic bsg_pkg::bsg_shape_s tone_shape(input logic [2:0] fsel,
                                                     input logic [2:0] lvl);
    logic [5:0] base;
    logic [5:0] high;
    bsg_pkg::bsg_shape_s s;
    base = fsel[1] ? 6'h0c : 6'h08;
    high = base - {3'h0, lvl};
    unique case (fsel)
      3'h0: s.period = 6'h10;
      3'h1: s.period = 6'h14;
      3'h2: s.period = 6'h18;
      3'h3: s.period = 6'h1c;
      3'h4: s.period = 6'h20;
      3'h5: s.period = 6'h28;
      3'h6: s.period = 6'h30;
      3'h7: s.period = 6'h38;
    endcase
    s.high = fsel[2] ? {high[4:0], 1'b0} : high;
    return s;
  endfunction : tone_shape

  function automatic logic bus_hit(input logic [AW-1:0] adr, input logic [7:0] ofs);
    return adr == AW'(ofs);
  endfunction : bus_hit

  // ****************************************************************************
  // Bus slave
  // ****************************************************************************
  logic        req;
  logic        wr_ctrl;
  logic        wr_setup;
  logic        next_ack;
  logic [31:0] next_dat;
  logic        busy;
  logic        trig_ok;
  logic        stop_ok;
  logic        restart_wr;
  logic [2:0]  env_lvl;
  logic        tone;
  bsg_pkg::bsg_ctrl_s ctrl;
  bsg_pkg::bsg_ctrl_s next_ctrl;
  bsg_pkg::bsg_shot_e st;

  assign req        = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_ctrl    = req && wb_we_i && wb_sel_i[0] && bus_hit(wb_adr_i, `BSG_OFS_CTRL);
  assign wr_setup   = req && wb_we_i && wb_sel_i[0] && bus_hit(wb_adr_i, `BSG_OFS_SETUP);
  assign restart_wr = wr_ctrl && wb_dat_i[`BSG_B_ENV_RST];
  assign trig_ok    = wr_ctrl && wb_dat_i[`BSG_B_SHOT_TRIG] && !ctrl.continuous_enable
                      && st == bsg_pkg::BSG_SHOT_IDLE;
  assign stop_ok    = wr_ctrl && wb_dat_i[`BSG_B_SHOT_STOP] && !ctrl.continuous_enable;
  assign busy       = st != bsg_pkg::BSG_SHOT_IDLE;

  always_comb begin
    next_ack = req;
    next_dat = 32'h0;
    if (req && !wb_we_i) begin
      if (bus_hit(wb_adr_i, `BSG_OFS_CTRL)) begin
        next_dat[`BSG_B_CONT]      = ctrl.continuous_enable;
        next_dat[`BSG_B_ENV_EN]    = ctrl.envelope_enable;
        next_dat[`BSG_B_ENV_TIME]  = ctrl.envelope_step_time_select;
        next_dat[`BSG_B_SHOT_LEN]  = ctrl.one_shot_length_select;
        next_dat[`BSG_B_SHOT_TRIG] = busy;
      end else if (bus_hit(wb_adr_i, `BSG_OFS_SETUP)) begin
        next_dat[`BSG_F_FREQ_LSB +: 3]  = ctrl.frequency_select;
        next_dat[`BSG_F_LEVEL_LSB +: 3] = ctrl.level_select;
      end else if (bus_hit(wb_adr_i, `BSG_OFS_STATUS)) begin
        next_dat[`BSG_F_ENVL_LSB +: 3] = env_lvl;
        next_dat[`BSG_B_TONE]          = tone;
      end
    end
  end

  always_comb begin
    next_ctrl = ctrl;
    if (wr_ctrl) begin
      next_ctrl.continuous_enable         = wb_dat_i[`BSG_B_CONT];
      next_ctrl.envelope_enable           = wb_dat_i[`BSG_B_ENV_EN];
      next_ctrl.envelope_step_time_select = wb_dat_i[`BSG_B_ENV_TIME];
      next_ctrl.one_shot_length_select    = wb_dat_i[`BSG_B_SHOT_LEN];
      if (trig_ok) begin
        next_ctrl.envelope_enable = 1'b0;
      end
    end
    if (wr_setup) begin
      next_ctrl.frequency_select = wb_dat_i[`BSG_F_FREQ_LSB +: 3];
      next_ctrl.level_select     = wb_dat_i[`BSG_F_LEVEL_LSB +: 3];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
      ctrl     <= '{continuous_enable: 1'b0, envelope_enable: 1'b0,
                    envelope_step_time_select: 1'b0, one_shot_length_select: 1'b0,
                    frequency_select: `BSG_RST_FREQ, level_select: `BSG_RST_LEVEL};
    end else begin
      wb_ack_o <= next_ack;
      wb_dat_o <= next_dat;
      ctrl     <= next_ctrl;
    end
  end

  // ****************************************************************************
  // Oscillator half-tick and 256 Hz timebase
  // ****************************************************************************
  logic [15:0] half_cnt;
  logic [15:0] next_half_cnt;
  logic [7:0]  tb_cnt;
  logic [7:0]  next_tb_cnt;
  logic        half_tick;
  logic        tb_tick;

  assign half_tick = half_cnt == 16'(HALF_DIV - 1);
  assign tb_tick   = half_tick && tb_cnt == 8'(HALF_PER_TB - 1);

  always_comb begin
    next_half_cnt = half_tick ? 16'h0 : half_cnt + 16'h1;
    next_tb_cnt   = tb_cnt;
    if (half_tick) begin
      next_tb_cnt = tb_cnt + 8'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      half_cnt <= 16'h0;
      tb_cnt   <= 8'h0;
    end else begin
      half_cnt <= next_half_cnt;
      tb_cnt   <= next_tb_cnt;
    end
  end

  // ****************************************************************************
  // One-shot burst
  // ****************************************************************************
  logic [5:0] shot_cnt;
  logic [5:0] next_shot_cnt;
  logic [5:0] shot_len;
  bsg_pkg::bsg_shot_e next_st;

  assign shot_len = ctrl.one_shot_length_select ? 6'(SHOT_LONG_T) : 6'(SHOT_SHORT_T);

  always_comb begin
    next_st       = st;
    next_shot_cnt = shot_cnt;
    unique case (st)
      bsg_pkg::BSG_SHOT_IDLE: begin
        next_shot_cnt = 6'h0;
        if (trig_ok) begin
          next_st = bsg_pkg::BSG_SHOT_ARMED;
        end
      end
      bsg_pkg::BSG_SHOT_ARMED: begin
        if (tb_tick) begin
          next_st = bsg_pkg::BSG_SHOT_PLAY;
        end
      end
      bsg_pkg::BSG_SHOT_PLAY: begin
        if (tb_tick) begin
          next_shot_cnt = shot_cnt + 6'h1;
          if (shot_cnt == shot_len - 6'h1) begin
            next_st = bsg_pkg::BSG_SHOT_IDLE;
          end
        end
      end
      default: begin
        next_st = bsg_pkg::BSG_SHOT_IDLE;
      end
    endcase
    if (stop_ok) begin
      next_st = bsg_pkg::BSG_SHOT_IDLE;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st       <= bsg_pkg::BSG_SHOT_IDLE;
      shot_cnt <= 6'h0;
    end else begin
      st       <= next_st;
      shot_cnt <= next_shot_cnt;
    end
  end

  // ****************************************************************************
  // Envelope
  // ****************************************************************************
  logic       cont_d;
  logic [5:0] env_cnt;
  logic [5:0] next_env_cnt;
  logic [2:0] next_env_lvl;
  logic [5:0] env_len;

  assign env_len = ctrl.envelope_step_time_select ? 6'(ENV_LONG_T) : 6'(ENV_SHORT_T);

  always_comb begin
    next_env_lvl = env_lvl;
    next_env_cnt = env_cnt;
    if (!ctrl.continuous_enable || !cont_d || restart_wr) begin
      next_env_lvl = 3'h0;
      next_env_cnt = 6'h0;
    end else if (tb_tick && env_lvl != LEVEL_MIN) begin
      next_env_cnt = env_cnt + 6'h1;
      if (env_cnt >= env_len - 6'h1) begin
        next_env_cnt = 6'h0;
        next_env_lvl = env_lvl + 3'h1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cont_d  <= 1'b0;
      env_cnt <= 6'h0;
      env_lvl <= 3'h0;
    end else begin
      cont_d  <= ctrl.continuous_enable;
      env_cnt <= next_env_cnt;
      env_lvl <= next_env_lvl;
    end
  end

  // ****************************************************************************
  // Tone waveform
  // ****************************************************************************
  logic       active;
  logic [2:0] eff_lvl;
  logic [5:0] phase;
  logic [5:0] next_phase;
  logic       next_tone;
  bsg_pkg::bsg_shape_s shape;

  assign active  = ctrl.continuous_enable || st == bsg_pkg::BSG_SHOT_PLAY;
  assign eff_lvl = ctrl.envelope_enable ? env_lvl : ctrl.level_select;
  assign shape   = tone_shape(ctrl.frequency_select, eff_lvl);

  always_comb begin
    next_phase = phase;
    if (!active) begin
      next_phase = 6'h0;
    end else if (half_tick) begin
      next_phase = (phase >= shape.period - 6'h1) ? 6'h0 : phase + 6'h1;
    end
    next_tone = active && (phase < shape.high);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase <= 6'h0;
      tone  <= 1'b0;
    end else begin
      phase <= next_phase;
      tone  <= next_tone;
    end
  end

  assign buzzer_port_pin_o = tone;

  // ****************************************************************************
  // Assertions
  // ****************************************************************************
  sequence s_ctrl_wr;
    wr_ctrl;
  endsequence

  sequence s_bus_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence

  a_pin_low_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    (!ctrl.continuous_enable && st != bsg_pkg::BSG_SHOT_PLAY) |=> !buzzer_port_pin_o)
    else $error("pin not low while idle");

  a_stop_now: assert property (@(posedge clk_i) disable iff (rst_i)
    (s_ctrl_wr ##0 stop_ok) |=> st == bsg_pkg::BSG_SHOT_IDLE ##1 !buzzer_port_pin_o)
    else $error("forced stop did not end burst");

  a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    s_bus_req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a single cycle");

  a_trig_env_off: assert property (@(posedge clk_i) disable iff (rst_i)
    (s_ctrl_wr ##0 trig_ok) |=> !ctrl.envelope_enable && st == bsg_pkg::BSG_SHOT_ARMED)
    else $error("trigger left envelope on");

  a_start_align: assert property (@(posedge clk_i) disable iff (rst_i)
    (st == bsg_pkg::BSG_SHOT_ARMED && !stop_ok)
      |=> (st == bsg_pkg::BSG_SHOT_PLAY) == $past(tb_tick))
    else $error("burst start not on timebase edge");

  a_end_align: assert property (@(posedge clk_i) disable iff (rst_i)
    (st == bsg_pkg::BSG_SHOT_PLAY && !tb_tick && !stop_ok)
      |=> st == bsg_pkg::BSG_SHOT_PLAY)
    else $error("burst ended off the timebase edge");

  a_env_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    (env_lvl == LEVEL_MIN && ctrl.continuous_enable && cont_d && !restart_wr)
      |=> env_lvl == LEVEL_MIN)
    else $error("envelope left minimum level");

  a_env_restart: assert property (@(posedge clk_i) disable iff (rst_i)
    (s_ctrl_wr ##0 restart_wr) |=> env_lvl == 3'h0)
    else $error("envelope restart ignored");

  a_env_start: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(ctrl.continuous_enable) |=> env_lvl == 3'h0)
    else $error("envelope did not start at level one");

  a_cont_ignore: assert property (@(posedge clk_i) disable iff (rst_i)
    (ctrl.continuous_enable && st == bsg_pkg::BSG_SHOT_IDLE) |=> st == bsg_pkg::BSG_SHOT_IDLE)
    else $error("one-shot started during continuous output");

  a_busy_read: assert property (@(posedge clk_i) disable iff (rst_i)
    (s_bus_req ##0 (!wb_we_i && bus_hit(wb_adr_i, `BSG_OFS_CTRL)))
      |=> wb_dat_o[`BSG_B_SHOT_TRIG] == $past(busy))
    else $error("busy bit misreported");

  a_phase_range: assert property (@(posedge clk_i) disable iff (rst_i)
    (active && half_tick && phase < shape.period && !wr_setup && !wr_ctrl)
      |=> phase < $past(shape.period))
    else $error("tone phase past its period");

endmodule : bsg_top

// ==== bsg_testbench.sv ====
// Purpose: Self-checking bench for the buzzer tone generator.
// Assumes: HALF_DIV of 2, so one 256 Hz timebase tick is 512 clocks.
// Notes:   Read data is checked from a queue of expected words as each ack appears.
`timescale 1ns/1ps
`include "bsg_defs.svh"

module testbench;
  localparam int HD    = 2;
  localparam int TK    = 256 * HD;
  localparam int CEIL  = 80000;
  localparam int DV[8] = '{8, 10, 12, 14, 16, 20, 24, 28};

  logic        clk, rst, cyc, stb, we, ack, pin;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] dat, rdat, d;
  int          err_total, tests_run, seed, span, t0, tt, last, n;
  int          cycles = 0;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];

  bsg_top #(.HALF_DIV(HD), .AW(8)) u_bsg_top (
    .clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .buzzer_port_pin_o(pin));

  initial clk = 1'b0;
  always #2 clk = ~clk;

  // ****************************************************************************
  // Checking and bus tasks
  // ****************************************************************************
  task automatic chk(input bit ok, input string msg);
    tests_run++;
    if (!ok) begin
      err_total++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask : chk

  task automatic close_out();
    $display("counts: %0d checks, %0d mismatches", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : close_out

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] dw,
                     input logic [31:0] e, input logic [31:0] m);
    int k;
    k = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= dw;
    sel <= 4'hf;
    if (!w) begin
      exp_q.push_back(e);
      msk_q.push_back(m);
    end
    // The request stands until the rising edge at which ack is sampled high.
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && k < 50);
    chk(ack === 1'b1, "no ack");
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] dw);
    bus(1'b1, a, dw, 32'h0, 32'h0);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    bus(1'b0, a, 32'h0, e, m);
  endtask : rd

  // Read data is compared while ack stands, against the oldest note.
  always @(negedge clk) begin
    if (ack === 1'b1 && we === 1'b0) begin
      if (exp_q.size() == 0)
        chk(1'b0, "read data with no note");
      else begin
        chk((rdat & msk_q[0]) === (exp_q[0] & msk_q[0]), $sformatf("read %h", rdat));
        void'(exp_q.pop_front());
        void'(msk_q.pop_front());
      end
    end
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == CEIL) begin
      err_total++;
      $display("mismatch at %0t: timeout", $time);
      close_out();
    end
  end

  // ****************************************************************************
  // Tone measurement
  // ****************************************************************************
  function automatic int hh(input int f, input int l);
    case (f)
      0, 1:    return 8 - l;
      4, 5:    return 2 * (8 - l);
      2, 3:    return 12 - l;
      default: return 2 * (12 - l);
    endcase
  endfunction : hh

  task automatic wait_pin(input logic v);
    int k;
    k = 0;
    while (pin !== v && k < 1200) begin
      @(negedge clk);
      k++;
    end
  endtask : wait_pin

  // Skips the period in progress and one more, then times one whole period from a rise.
  task automatic tone(input int f, input int l);
    int hi;
    int lo;
    hi = 0;
    lo = 0;
    @(negedge clk);
    wait_pin(1'b0);
    wait_pin(1'b1);
    wait_pin(1'b0);
    wait_pin(1'b1);
    while (pin === 1'b1 && hi < 400) begin
      @(negedge clk);
      hi++;
    end
    while (pin === 1'b0 && lo < 400) begin
      @(negedge clk);
      lo++;
    end
    chk(hi == hh(f, l) * HD && hi + lo == 2 * DV[f] * HD,
        $sformatf("tone f%0d l%0d high %0d period %0d", f, l, hi, hi + lo));
  endtask : tone

  task automatic stay_low(input int cnt, input string msg);
    int bad;
    bad = 0;
    repeat (cnt) begin
      @(negedge clk);
      if (pin !== 1'b0) bad++;
    end
    chk(bad == 0, msg);
  endtask : stay_low

  // ****************************************************************************
  // Main sequence
  // ****************************************************************************
  initial begin
    err_total = 0;
    tests_run = 0;
    seed = 32'h3742;
    rst = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we  = 1'b0;
    adr = 8'h00;
    sel = 4'h0;
    dat = 32'h0;
    repeat (16) @(posedge clk);
    stay_low(4, "pin high in reset");
    @(posedge clk);
    rst <= 1'b0;
    rd(`BSG_OFS_CTRL, 32'h0, 32'hffffffff);
    rd(`BSG_OFS_SETUP, 32'h0, 32'hffffffff);
    rd(`BSG_OFS_STATUS, 32'h0, 32'hffffffff);
    rd(8'h0c, 32'h0, 32'hffffffff);
    d = $random(seed) & 32'h77;
    wr(`BSG_OFS_SETUP, d);
    wr(8'h0c, 32'hff);
    rd(`BSG_OFS_SETUP, d, 32'h77);
    $display("test reset and setup done");

    for (int f = 0; f < 8; f++) begin
      wr(`BSG_OFS_CTRL, 32'h0);
      wr(`BSG_OFS_SETUP, 32'((7 - f) << 4 | f));
      wr(`BSG_OFS_CTRL, 32'h1);
      tone(f, 7 - f);
    end
    wr(`BSG_OFS_CTRL, 32'h0);
    stay_low(200, "pin active with output off");
    $display("test tone table done");

    wr(`BSG_OFS_SETUP, 32'h70);
    wr(`BSG_OFS_CTRL, 32'h3);
    tone(0, 0);
    repeat (16 * TK + TK / 4) @(posedge clk);
    rd(`BSG_OFS_STATUS, 32'h1, 32'h7);
    tone(0, 1);
    wr(`BSG_OFS_CTRL, 32'h7);
    rd(`BSG_OFS_STATUS, 32'h0, 32'h7);
    wr(`BSG_OFS_CTRL, 32'h0);
    wr(`BSG_OFS_CTRL, 32'h0b);
    repeat (16 * TK + TK / 2) @(posedge clk);
    rd(`BSG_OFS_STATUS, 32'h0, 32'h7);
    repeat (16 * TK) @(posedge clk);
    rd(`BSG_OFS_STATUS, 32'h1, 32'h7);
    wr(`BSG_OFS_CTRL, 32'h0);
    $display("test envelope done");

    for (int len = 0; len < 2; len++) begin
      wr(`BSG_OFS_CTRL, 32'(32'h22 | len << 4));
      tt = cycles;
      rd(`BSG_OFS_CTRL, 32'(32'h20 | len << 4), 32'h7f);
      wait_pin(1'b1);
      t0 = cycles;
      chk(t0 - tt <= TK + 4, "burst start late");
      tone(0, 7);
      n = 0;
      last = t0;
      while (n < 200) begin
        @(negedge clk);
        if (pin === 1'b1) begin
          n = 0;
          last = cycles;
        end else
          n++;
      end
      span = last - t0;
      chk(span < (len ? 32 : 8) * TK && span > (len ? 32 : 8) * TK - 34,
          $sformatf("burst span %0d", span));
      rd(`BSG_OFS_CTRL, 32'h0, 32'h20);
    end
    $display("test one-shot done");

    wr(`BSG_OFS_CTRL, 32'h30);
    wait_pin(1'b1);
    wr(`BSG_OFS_CTRL, 32'h40);
    stay_low(300, "pin active after forced stop");
    rd(`BSG_OFS_CTRL, 32'h0, 32'h20);
    wr(`BSG_OFS_CTRL, 32'h1);
    wr(`BSG_OFS_CTRL, 32'h21);
    rd(`BSG_OFS_CTRL, 32'h1, 32'h7f);
    wr(`BSG_OFS_CTRL, 32'h41);
    tone(0, 7);
    wr(`BSG_OFS_CTRL, 32'h0);
    stay_low(200, "pin active with output off");
    $display("test stop and ignore done");
    close_out();
  end
endmodule : testbench
